// ### common/tsp_defs.vh
// Constants for the serial command port of the time converter.
// Included by the port design; holds definitions only.
`ifndef TSP_DEFS_VH
`define TSP_DEFS_VH

// Core clock period and hit hold-off after reset release
`define TSP_CLK_PERIOD_NS   25
`define TSP_HIT_HOLD_NS     30

// Operation codes
`define TSP_OP_WR_FIRST     8'h80
`define TSP_OP_WR_LAST      8'h84
`define TSP_OP_RD_UP_FIRST  8'hB0
`define TSP_OP_RD_UP_LAST   8'hB7
`define TSP_OP_RD_UP_SUM    8'hB8
`define TSP_OP_RD_DN_FIRST  8'hB9
`define TSP_OP_RD_DN_LAST   8'hC0

// Word layout
`define TSP_WORD_BITS       32
`define TSP_CFG_COUNT       5
`define TSP_HIT_COUNT       8
`define TSP_BYTES_PER_WORD  3'h4

// Reset values
`define TSP_CFG_RESET       32'h00000000
`define TSP_PIN_IDLE        3'h1

`endif

// ### hdl/tsp_cmd_port.v
// Serial command port of a time converter: SPI slave, mode CPHA 1 / CPOL 0.
// Assumes one core clock; SPI pins arrive asynchronously and are oversampled.
// Function
// - Slave works with clock phase one, polarity zero; idle serial clock low.
// - First serial clock rise in a transfer releases the interrupt line.
// - Every byte shifts most significant bit first, both directions.
// - Received bits are only acted on in complete eight-bit groups.
// - A select low-high-low pulse after any byte ends the transfer.
// - Input data is sampled on the serial clock falling edge.
// - Output data changes after the serial clock rising edge.
// - Reset held 30 ns by master; hits ignored two core cycles (30 ns rounded up to 50 ns) after release.
// - First byte of each transfer is the operation code.
// - Codes 0x80 to 0x84 write configuration registers zero to four.
// - Codes 0xB0 to 0xB7 read upstream hit results one to eight.
// - Code 0xB8 reads the upstream sum of eight hit results.
// - Code 0xB9 reads first downstream hit result, downstream codes follow.
`include "tsp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tsp_cmd_port (
  // Clock and reset
  input  wire         core_clk,
  input  wire         srst,
  // Serial pins
  input  wire         chip_select_low,
  input  wire         sck,
  input  wire         sdi,
  output reg          sdo_out,
  output reg          sdo_oe,
  // Interrupt
  input  wire         meas_done,
  output reg          irq_line_low,
  // Measurement hits
  input  wire         hit_in,
  output reg          hit_accept,
  // Configuration registers, register n in bits 32n+31..32n
  output reg  [159:0] cfg_regs,
  output reg  [4:0]   cfg_wr_strobe,
  // Result registers, hit n in bits 32n+31..32n
  input  wire [255:0] up_results,
  input  wire [31:0]  up_sum,
  input  wire [255:0] dn_results
);

  localparam integer    HOLD_CYC_I = (`TSP_HIT_HOLD_NS + `TSP_CLK_PERIOD_NS - 1)
                                     / `TSP_CLK_PERIOD_NS;
  localparam [1:0]      HOLD_CYC   = HOLD_CYC_I[1:0];
  // Idle level of each pin, used to preload the synchronisers
  localparam [2:0]      PIN_IDLE   = `TSP_PIN_IDLE;

  localparam [1:0]      ST_OPCODE  = 2'h0;
  localparam [1:0]      ST_WRITE   = 2'h1;
  localparam [1:0]      ST_READ    = 2'h2;
  localparam [1:0]      ST_IGNORE  = 2'h3;

  localparam [1:0]      KIND_NONE  = 2'h0;
  localparam [1:0]      KIND_WR    = 2'h1;
  localparam [1:0]      KIND_RD    = 2'h2;

  // Pin bits: 0 select, 1 serial clock, 2 data in
  wire [2:0]            pin_raw;
  wire [2:0]            pin_next;
  reg  [2:0]            sync1_reg;
  reg  [2:0]            sync2_reg;
  reg  [2:0]            sync3_reg;
  reg  [2:0]            pin_st_reg;

  reg  [1:0]            state_reg;
  reg  [2:0]            bit_cnt_reg;
  reg  [2:0]            byte_cnt_reg;
  reg  [6:0]            in_sh_reg;
  reg  [23:0]           wr_buf_reg;
  reg  [2:0]            wr_idx_reg;
  reg  [31:0]           out_sh_reg;
  reg                   first_rise_reg;
  reg  [1:0]            hold_cnt_reg;

  wire                  cs_active;
  wire                  sck_rise;
  wire                  sck_fall;
  wire [7:0]            byte_val;
  wire                  byte_done;
  wire [1:0]            op_class;

  assign pin_raw = {sdi, sck, chip_select_low};

  // Three-stage synchronisers; a level counts once stages two and three agree.
  // This costs about three core cycles per pin edge, so serial clock phases
  // must last at least four core cycles.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      always @(posedge core_clk) begin
        if (srst) begin
          sync1_reg[gi]  <= PIN_IDLE[gi];
          sync2_reg[gi]  <= PIN_IDLE[gi];
          sync3_reg[gi]  <= PIN_IDLE[gi];
          pin_st_reg[gi] <= PIN_IDLE[gi];
        end else begin
          sync1_reg[gi]  <= pin_raw[gi];
          sync2_reg[gi]  <= sync1_reg[gi];
          sync3_reg[gi]  <= sync2_reg[gi];
          pin_st_reg[gi] <= pin_next[gi];
        end
      end
      assign pin_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi]
                                                             : pin_st_reg[gi];
    end
  endgenerate

  assign cs_active = ~pin_next[0];
  assign sck_rise  = cs_active & pin_next[1] & ~pin_st_reg[1];
  assign sck_fall  = cs_active & ~pin_next[1] & pin_st_reg[1];
  assign byte_val  = {in_sh_reg, pin_next[2]};
  assign byte_done = sck_fall & (bit_cnt_reg == 3'h7);
  assign op_class  = op_kind(byte_val);

  // Bit offset of word n inside a packed bank
  function [7:0] word_base;
    input [2:0] idx;
    begin
      word_base = {idx, 5'h00};
    end
  endfunction

  // Classify an operation code
  function [1:0] op_kind;
    input [7:0] op;
    begin
      if (op >= `TSP_OP_WR_FIRST && op <= `TSP_OP_WR_LAST)
        op_kind = KIND_WR;
      else if (op >= `TSP_OP_RD_UP_FIRST && op <= `TSP_OP_RD_DN_LAST)
        op_kind = KIND_RD;
      else
        op_kind = KIND_NONE;
    end
  endfunction

  // Pick the result word that a read code returns
  function [31:0] result_word;
    input [7:0] op;
    reg   [7:0] ofs;
    begin
      ofs = 8'h00;
      result_word = 32'h00000000;
      if (op <= `TSP_OP_RD_UP_LAST) begin
        ofs = op - `TSP_OP_RD_UP_FIRST;
        result_word = up_results[word_base(ofs[2:0]) +: 32];
      end else if (op == `TSP_OP_RD_UP_SUM) begin
        result_word = up_sum;
      end else begin
        ofs = op - `TSP_OP_RD_DN_FIRST;
        result_word = dn_results[word_base(ofs[2:0]) +: 32];
      end
    end
  endfunction

  // Serial protocol engine; only the opcode byte and deselect move the state
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg      <= ST_OPCODE;
      bit_cnt_reg    <= 3'h0;
      in_sh_reg      <= 7'h00;
      out_sh_reg     <= 32'h00000000;
      first_rise_reg <= 1'b1;
      sdo_out        <= 1'b0;
    end else begin
      if (!cs_active) begin
        state_reg      <= ST_OPCODE;
        bit_cnt_reg    <= 3'h0;
        first_rise_reg <= 1'b1;
        sdo_out        <= 1'b0;
      end else begin
        if (sck_fall) begin
          in_sh_reg   <= byte_val[6:0];
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (byte_done && state_reg == ST_OPCODE) begin
          case (op_class)
            KIND_WR: begin
              state_reg <= ST_WRITE;
            end
            KIND_RD: begin
              // load result
              // Word is a snapshot; bits past it read as zero
              state_reg  <= ST_READ;
              out_sh_reg <= result_word(byte_val);
            end
            default: begin
              // Unknown code: rest of the transfer is ignored
              state_reg <= ST_IGNORE;
            end
          endcase
        end
        if (sck_rise) begin
          first_rise_reg <= 1'b0;
          if (state_reg == ST_READ) begin
            sdo_out    <= out_sh_reg[31];
            out_sh_reg <= {out_sh_reg[30:0], 1'b0};
          end else begin
            sdo_out <= 1'b0;
          end
        end
      end
    end
  end

  // Configuration write path; a partial word at deselect is dropped
  always @(posedge core_clk) begin
    if (srst) begin
      byte_cnt_reg  <= 3'h0;
      wr_buf_reg    <= 24'h000000;
      wr_idx_reg    <= 3'h0;
      cfg_regs      <= {`TSP_CFG_COUNT{`TSP_CFG_RESET}};
      cfg_wr_strobe <= 5'h00;
    end else begin
      cfg_wr_strobe <= 5'h00;
      if (!cs_active) begin
        byte_cnt_reg <= 3'h0;
      end else if (byte_done) begin
        if (state_reg == ST_OPCODE) begin
          byte_cnt_reg <= 3'h0;
          wr_buf_reg   <= 24'h000000;
          if (op_class == KIND_WR) begin
            wr_idx_reg <= byte_val[2:0];
          end
        end else if (state_reg == ST_WRITE) begin
          // collect and commit word
          // Further groups of four rewrite the same register
          if (byte_cnt_reg == `TSP_BYTES_PER_WORD - 3'h1) begin
            cfg_regs[word_base(wr_idx_reg) +: 32] <= {wr_buf_reg, byte_val};
            cfg_wr_strobe[wr_idx_reg]             <= 1'b1;
            byte_cnt_reg                          <= 3'h0;
          end else begin
            wr_buf_reg   <= {wr_buf_reg[15:0], byte_val};
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
          end
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= cs_active;
    end
  end

  // Interrupt line: a completion event wins over the clear
  always @(posedge core_clk) begin
    if (srst) begin
      irq_line_low <= 1'b1;
    end else if (meas_done) begin
      irq_line_low <= 1'b0;
    end else if (sck_rise && first_rise_reg) begin
      irq_line_low <= 1'b1;
    end
  end

  // Hit hold-off after reset release; counts down once and then rests at zero
  always @(posedge core_clk) begin
    if (srst) begin
      hold_cnt_reg <= HOLD_CYC;
    end else if (hold_cnt_reg != 2'h0) begin
      hold_cnt_reg <= hold_cnt_reg - 2'h1;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      hit_accept <= 1'b0;
    end else begin
      hit_accept <= hit_in & (hold_cnt_reg == 2'h0);
    end
  end

endmodule

`default_nettype wire

// ### verif/tsp_cmd_port_monitor.sv
// Checker for the serial command port outputs.
// Assumes serial pins change slowly against core_clk.
`timescale 1ns/1ps
`default_nettype none
module tsp_chk (
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         srst,
  // Observed ports
  input wire logic         chip_select_low,
  input wire logic         sck,
  input wire logic         sdo_oe,
  input wire logic         meas_done,
  input wire logic         irq_line_low,
  input wire logic         hit_accept,
  input wire logic [159:0] cfg_regs,
  input wire logic [4:0]   cfg_wr_strobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_sel; $fell(chip_select_low); endsequence
  sequence s_unsel; $rose(chip_select_low); endsequence
  property p_irq_set; meas_done |=> !irq_line_low; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq set");
  property p_irq_clr;
    $rose(sck) && !chip_select_low && !irq_line_low |-> ##[1:8] irq_line_low;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq clear");
  property p_oe_on; s_sel |-> ##[1:8] sdo_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe on");
  property p_oe_off; s_unsel |-> ##[1:8] !sdo_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe off");
  property p_hold_off; $fell(srst) |=> !hit_accept [*2]; endproperty
  a_hold_off: assert property (p_hold_off) else $error("hit hold");
  property p_strobe_one; $onehot0(cfg_wr_strobe); endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe");
  property p_strobe_pulse; |cfg_wr_strobe |=> cfg_wr_strobe == 5'h0; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("pulse");
  property p_cfg_hold; !$stable(cfg_regs) |-> |cfg_wr_strobe; endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg change");
endmodule
bind tsp_cmd_port tsp_chk u_tsp_chk (.*);
`default_nettype wire

// ### verif/tsp_host.sv
// Host SPI master model, phase 1 polarity 0, 200 ns clock.
// Assumes the bench calls xfer one transfer at a time.
`timescale 1ns/1ps
`default_nettype none
module tsp_host (
  output var logic chip_select_low,
  output var logic sck,
  output var logic sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  initial begin
    chip_select_low = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic xfer(input logic [39:0] d, input int n, output logic [31:0] rd);
    rd = 32'h0;
    chip_select_low = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sdi = d[39-i];
      sck = 1'b1;
      #100;
      sck = 1'b0;
      #100;
      // read after fall, released line toggles
      rd = {rd[30:0], sdo_oe ? sdo_out : ~rd[0]};
    end
    chip_select_low = 1'b1;
    sdi = ~sdi;
    #400;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the serial command port.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         core_clk = 1'b0;
  logic         srst = 1'b1;
  logic         meas_done = 1'b0;
  logic         hit_in = 1'b0;
  logic [255:0] up_results, dn_results;
  logic [31:0]  up_sum = 32'h5A5A_0F0F;
  logic [31:0]  rd;
  wire          chip_select_low, sck, sdi, sdo_out, sdo_oe, irq_line_low, hit_accept;
  wire  [159:0] cfg_regs;
  wire  [4:0]   cfg_wr_strobe;
  int           miscompares = 0, check_count = 0, k;
  initial forever #12.5 core_clk = ~core_clk;
  tsp_cmd_port u_tsp_cmd_port (
    .core_clk(core_clk), .srst(srst), .chip_select_low(chip_select_low), .sck(sck),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .meas_done(meas_done),
    .irq_line_low(irq_line_low), .hit_in(hit_in), .hit_accept(hit_accept),
    .cfg_regs(cfg_regs), .cfg_wr_strobe(cfg_wr_strobe), .up_results(up_results),
    .up_sum(up_sum), .dn_results(dn_results));
  tsp_host u_tsp_host (
    .chip_select_low(chip_select_low), .sck(sck), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_write;
    for (k = 0; k < 5; k++) begin
      u_tsp_host.xfer({8'h80 + 8'(k), 32'hF00D_1E00 | 32'(k)}, 40, rd);
      cmp(cfg_regs[32*k +: 32], 32'hF00D_1E00 | 32'(k));
    end
    $display("write done");
  endtask
  task t_abort;
    u_tsp_host.xfer({8'h82, 8'h84, 24'h0}, 16, rd);
    u_tsp_host.xfer({8'h81, 32'h0}, 8, rd);
    u_tsp_host.xfer({8'h83, 32'h0BAD_CAFE}, 40, rd);
    cmp(cfg_regs[95:64], 32'hF00D_1E02);
    cmp(cfg_regs[127:96], 32'h0BAD_CAFE);
    cmp(cfg_regs[159:128], 32'hF00D_1E04);
    $display("abort done");
  endtask
  task t_read;
    for (k = 0; k < 10; k++) begin
      u_tsp_host.xfer({8'hB0 + 8'(k), 32'h0}, 40, rd);
      cmp(rd, k < 8 ? up_results[32*k +: 32] : k == 8 ? up_sum : dn_results[31:0]);
    end
    $display("read done");
  endtask
  task t_irq;
    @(negedge core_clk) meas_done = 1'b1;
    @(negedge core_clk) meas_done = 1'b0;
    cmp(irq_line_low, 1'b0);
    u_tsp_host.xfer({8'hB1, 32'h0}, 8, rd);
    cmp(irq_line_low, 1'b1);
    $display("irq done");
  endtask
  task t_hit;
    @(negedge core_clk) srst = 1'b1;
    hit_in = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk) cmp(hit_accept, 1'b0);
    repeat (4) @(negedge core_clk);
    cmp(hit_accept, 1'b1);
    cmp(cfg_regs[31:0], 32'h0);
    hit_in = 1'b0;
    $display("hit done");
  endtask
  initial begin
    for (k = 0; k < 8; k++) begin
      up_results[32*k +: 32] = 32'hA5C3_0F00 + 32'h0101_0101 * k;
      dn_results[32*k +: 32] = 32'h9E17_4400 + 32'h0202_0203 * k;
    end
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_write;
    t_abort;
    t_read;
    t_irq;
    repeat (20000) @(negedge core_clk);
    t_hit;
    report_and_stop;
  end
  // About 20 transfers of 8.5 us each plus 500 us settling, with margin
  initial begin
    #1000000;
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
